// ==== logic/asf_pkg.sv ====
//
// Behaviour
// - Frame opens with one low start bit
// - Stop period one or two high bits
// - Seven or eight data bits, optional parity
// - Mode bits select 7-bit or 8-bit async
// - Parity enable inserts and checks parity bit
// - Parity kind one is odd, zero even
// - Bit order select: LSB or MSB first
// - Separate transmit and receive shift registers
// - Pins stay port pins until serial enabled
// - Clock and ready pins stay port pins
// - Two-bit field picks shift clock source
// - Stop and bit-order bits share one address with enables
// - Transmit enable zero resets the transmitter
// - Seven-bit mode ignores top data bit
// - Trigger starts clock, start bit on edge
// - One new bit per OVERSAMPLE shift clock edges
// - Line held high after frame until start
// - Frame end sets transmit done flag
// - Parity makes ones count even or odd
`default_nettype none

package asf_pkg;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_CFG    = 8'h04;
   localparam logic [7:0] ADDR_TXDATA = 8'h08;
   localparam logic [7:0] ADDR_CMD    = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam logic [7:0] ADDR_RXDATA = 8'h14;

   // Control word: pin routing, mode, parity, clock source
   localparam int CTRL_PIN_SEL  = 0;
   localparam int CTRL_MODE_LO  = 1;
   localparam int CTRL_MODE_HI  = 2;
   localparam int CTRL_PAR_EN   = 3;
   localparam int CTRL_PAR_ODD  = 4;
   localparam int CTRL_CSRC_LO  = 5;
   localparam int CTRL_CSRC_HI  = 6;

   localparam int CFG_TX_EN     = 0;
   localparam int CFG_RX_EN     = 1;
   localparam int CFG_TWO_STOP  = 2;
   localparam int CFG_MSB_FIRST = 3;

   localparam int CMD_TX_TRIG   = 0;
   localparam int CMD_RX_ACK    = 1;

   localparam int STAT_TX_DONE  = 0;
   localparam int STAT_RX_FULL  = 1;
   localparam int STAT_PERR     = 2;
   localparam int STAT_FERR     = 3;
   localparam int STAT_OERR     = 4;
   localparam int STAT_TX_BUSY  = 5;

   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] CFG_RST  = 8'h00;

   // ****************************************************************
   // Clock sources, pins, timing
   // ****************************************************************
   localparam logic [1:0] CSRC_TIMER = 2'h0;
   localparam logic [1:0] CSRC_OSC1  = 2'h1;
   localparam logic [1:0] CSRC_OSC2  = 2'h2;
   localparam logic [1:0] CSRC_OSC4  = 2'h3;

   localparam int PIN_SIN  = 0;
   localparam int PIN_SOUT = 1;
   localparam int PIN_SCLK = 2;
   localparam int PIN_RDY  = 3;

   localparam int OVERSAMPLE = 16;
   localparam int CNT_W      = 8;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [2:0] {
      TX_IDLE   = 3'h0,
      TX_WAIT   = 3'h1,
      TX_START  = 3'h2,
      TX_DATA   = 3'h3,
      TX_PARITY = 3'h4,
      TX_STOP   = 3'h5
   } asf_tx_state_t;

   typedef enum logic [2:0] {
      RX_IDLE   = 3'h0,
      RX_START  = 3'h1,
      RX_DATA   = 3'h2,
      RX_PARITY = 3'h3,
      RX_STOP   = 3'h4
   } asf_rx_state_t;

   typedef struct packed {
      logic [3:0] o;
      logic [3:0] oe;
   } asf_pad_t;

   // Whole module state; all-zero is the reset value
   typedef struct packed {
      logic             bvalid;
      logic [1:0]       bresp;
      logic             rvalid;
      logic [1:0]       rresp;
      logic [31:0]      rdata;
      logic [7:0]       ctrl;
      logic [7:0]       cfg;
      logic [7:0]       txdata;
      logic [1:0]       osc_div;
      asf_tx_state_t    tx_st;
      logic [CNT_W-1:0] tx_cnt;
      logic [3:0]       tx_bits;
      logic             tx_stops;
      logic [7:0]       tx_sh;
      logic             tx_par;
      logic             tx_low;
      logic             tx_done;
      asf_rx_state_t    rx_st;
      logic [CNT_W-1:0] rx_cnt;
      logic [3:0]       rx_bits;
      logic [7:0]       rx_sh;
      logic             rx_par;
      logic [7:0]       rx_data;
      logic             rx_full;
      logic             perr;
      logic             ferr;
      logic             oerr;
   } asf_state_t;

endpackage : asf_pkg

`default_nettype wire

// ==== logic/asf_serial.sv ====
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module asf_serial #(
   parameter int OVERSAMPLE = asf_pkg::OVERSAMPLE
) (
   input  wire logic            CLOCK,
   input  wire logic            RST_N,
   input  wire logic            S_AXI_AWVALID,
   output logic                 S_AXI_AWREADY,
   input  wire logic [7:0]      S_AXI_AWADDR,
   input  wire logic            S_AXI_WVALID,
   output logic                 S_AXI_WREADY,
   input  wire logic [31:0]     S_AXI_WDATA,
   input  wire logic [3:0]      S_AXI_WSTRB,
   output logic                 S_AXI_BVALID,
   input  wire logic            S_AXI_BREADY,
   output logic [1:0]           S_AXI_BRESP,
   input  wire logic            S_AXI_ARVALID,
   output logic                 S_AXI_ARREADY,
   input  wire logic [7:0]      S_AXI_ARADDR,
   output logic                 S_AXI_RVALID,
   input  wire logic            S_AXI_RREADY,
   output logic [31:0]          S_AXI_RDATA,
   output logic [1:0]           S_AXI_RRESP,
   input  wire logic            TIMER_TICK,
   input  wire logic            OSC_TICK,
   input  wire asf_pkg::asf_pad_t PORT_PAD,
   input  wire logic [3:0]      PIN_I,
   output asf_pkg::asf_pad_t    PIN_PAD,
   output logic                 TX_DONE,
   output logic                 RX_FULL
);

   // ****************************************************************
   // Parameter check
   // ****************************************************************
   generate
      if (OVERSAMPLE < 4 || OVERSAMPLE > 256) begin : g_bad_ovs
         $error("OVERSAMPLE must lie in 4..256");
      end
   endgenerate

   localparam logic [asf_pkg::CNT_W-1:0] LAST_TICK =
      asf_pkg::CNT_W'(OVERSAMPLE - 1);
   localparam logic [asf_pkg::CNT_W-1:0] HALF_TICK =
      asf_pkg::CNT_W'(OVERSAMPLE / 2 - 1);

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic mapped(input logic [7:0] addr);
      mapped = (addr == asf_pkg::ADDR_CTRL)   ||
               (addr == asf_pkg::ADDR_CFG)    ||
               (addr == asf_pkg::ADDR_TXDATA) ||
               (addr == asf_pkg::ADDR_CMD)    ||
               (addr == asf_pkg::ADDR_STATUS) ||
               (addr == asf_pkg::ADDR_RXDATA);
   endfunction : mapped

   // Word placed so that bit 0 always goes out first
   function automatic logic [7:0] order_word(input logic [7:0] data,
                                             input logic       eight,
                                             input logic       msb);
      logic [7:0] w;
      logic [7:0] r;
      w = eight ? data : {1'b0, data[6:0]};
      r = '0;
      for (int i = 0; i < 8; i++) begin
         r[i] = w[7 - i];
      end
      if (!msb) begin
         order_word = w;
      end else if (eight) begin
         order_word = r;
      end else begin
         order_word = {1'b0, r[7:1]};
      end
   endfunction : order_word

   // ****************************************************************
   // State
   // ****************************************************************
   asf_pkg::asf_state_t q;
   asf_pkg::asf_state_t d;

   logic       tick;
   logic       wr_take;
   logic       rd_take;
   logic [7:0] wb;
   logic       wr_ctrl;
   logic       wr_cfg;
   logic       wr_tx;
   logic       wr_cmd;
   logic       wr_stat;
   logic       async_mode;
   logic       eight;
   logic       par_en;
   logic       par_odd;
   logic       msb_first;
   logic       sin;
   logic [3:0] last_bit;
   logic [7:0] status;

   assign S_AXI_AWREADY = wr_take;
   assign S_AXI_WREADY  = wr_take;
   assign S_AXI_ARREADY = rd_take;
   assign S_AXI_BVALID  = q.bvalid;
   assign S_AXI_BRESP   = q.bresp;
   assign S_AXI_RVALID  = q.rvalid;
   assign S_AXI_RDATA   = q.rdata;
   assign S_AXI_RRESP   = q.rresp;
   assign TX_DONE       = q.tx_done;
   assign RX_FULL       = q.rx_full;

   always_comb begin
      // ****************************************************************
      // Bus slave
      // ****************************************************************
      d          = q;
      async_mode = q.ctrl[asf_pkg::CTRL_MODE_HI];
      eight      = q.ctrl[asf_pkg::CTRL_MODE_LO];
      par_en     = q.ctrl[asf_pkg::CTRL_PAR_EN];
      par_odd    = q.ctrl[asf_pkg::CTRL_PAR_ODD];
      msb_first  = q.cfg[asf_pkg::CFG_MSB_FIRST];
      last_bit   = eight ? 4'h7 : 4'h6;
      status     = {2'h0, (q.tx_st != asf_pkg::TX_IDLE), q.oerr, q.ferr,
                    q.perr, q.rx_full, q.tx_done};

      // Address and data taken together, one write at a time
      wr_take = S_AXI_AWVALID && S_AXI_WVALID && !q.bvalid;
      rd_take = S_AXI_ARVALID && !q.rvalid;
      wb      = S_AXI_WSTRB[0] ? S_AXI_WDATA[7:0] : 8'h00;
      wr_ctrl = wr_take && S_AXI_WSTRB[0] &&
                (S_AXI_AWADDR == asf_pkg::ADDR_CTRL);
      wr_cfg  = wr_take && S_AXI_WSTRB[0] &&
                (S_AXI_AWADDR == asf_pkg::ADDR_CFG);
      wr_tx   = wr_take && S_AXI_WSTRB[0] &&
                (S_AXI_AWADDR == asf_pkg::ADDR_TXDATA);
      wr_cmd  = wr_take && S_AXI_WSTRB[0] &&
                (S_AXI_AWADDR == asf_pkg::ADDR_CMD);
      wr_stat = wr_take && S_AXI_WSTRB[0] &&
                (S_AXI_AWADDR == asf_pkg::ADDR_STATUS);

      if (q.bvalid && S_AXI_BREADY) begin
         d.bvalid = 1'b0;
      end
      if (q.rvalid && S_AXI_RREADY) begin
         d.rvalid = 1'b0;
      end
      if (wr_take) begin
         d.bvalid = 1'b1;
         d.bresp  = mapped(S_AXI_AWADDR) ? asf_pkg::RESP_OKAY
                                         : asf_pkg::RESP_SLVERR;
      end
      if (wr_ctrl) begin
         d.ctrl = {1'b0, wb[6:0]};
      end
      if (wr_cfg) begin
         d.cfg = {4'h0, wb[3:0]};
      end
      if (wr_tx) begin
         d.txdata = wb;
      end
      // Clears first so that a same-cycle hardware set wins
      if (wr_stat) begin
         if (wb[asf_pkg::STAT_TX_DONE]) d.tx_done = 1'b0;
         if (wb[asf_pkg::STAT_PERR])    d.perr    = 1'b0;
         if (wb[asf_pkg::STAT_FERR])    d.ferr    = 1'b0;
         if (wb[asf_pkg::STAT_OERR])    d.oerr    = 1'b0;
      end
      if (wr_cmd && wb[asf_pkg::CMD_RX_ACK]) begin
         d.rx_full = 1'b0;
      end

      if (rd_take) begin
         d.rvalid = 1'b1;
         d.rresp  = asf_pkg::RESP_OKAY;
         case (S_AXI_ARADDR)
            asf_pkg::ADDR_CTRL:   d.rdata = {24'h00_0000, q.ctrl};
            asf_pkg::ADDR_CFG:    d.rdata = {24'h00_0000, q.cfg};
            asf_pkg::ADDR_TXDATA: d.rdata = {24'h00_0000, q.txdata};
            asf_pkg::ADDR_CMD:    d.rdata = 32'h0000_0000;
            asf_pkg::ADDR_STATUS: d.rdata = {24'h00_0000, status};
            asf_pkg::ADDR_RXDATA: d.rdata = {24'h00_0000, q.rx_data};
            default: begin
               d.rdata = 32'h0000_0000;
               d.rresp = asf_pkg::RESP_SLVERR;
            end
         endcase
      end

      // ****************************************************************
      // Shift clock source
      // ****************************************************************
      d.osc_div = q.osc_div + {1'b0, OSC_TICK};
      case (q.ctrl[asf_pkg::CTRL_CSRC_HI:asf_pkg::CTRL_CSRC_LO])
         asf_pkg::CSRC_TIMER: tick = TIMER_TICK;
         asf_pkg::CSRC_OSC1:  tick = OSC_TICK;
         asf_pkg::CSRC_OSC2:  tick = OSC_TICK && q.osc_div[0];
         asf_pkg::CSRC_OSC4:  tick = OSC_TICK && (q.osc_div == 2'h3);
         default:             tick = 1'b0;
      endcase

      // ****************************************************************
      // Transmitter
      // ****************************************************************
      if (wr_cmd && wb[asf_pkg::CMD_TX_TRIG] && async_mode &&
          q.cfg[asf_pkg::CFG_TX_EN] && q.tx_st == asf_pkg::TX_IDLE) begin
         d.tx_sh  = order_word(q.txdata, eight, msb_first);
         d.tx_par = ^order_word(q.txdata, eight, 1'b0) ^ par_odd;
         d.tx_st  = asf_pkg::TX_WAIT;
      end else if (tick) begin
         if (q.tx_st == asf_pkg::TX_WAIT) begin
            d.tx_st  = asf_pkg::TX_START;
            d.tx_low = 1'b1;
            d.tx_cnt = '0;
         end else if (q.tx_st != asf_pkg::TX_IDLE) begin
            if (q.tx_cnt != LAST_TICK) begin
               d.tx_cnt = q.tx_cnt + 1'b1;
            end else begin
               d.tx_cnt = '0;
               case (q.tx_st)
                  asf_pkg::TX_START: begin
                     d.tx_st   = asf_pkg::TX_DATA;
                     d.tx_bits = 4'h0;
                     d.tx_low  = ~q.tx_sh[0];
                  end
                  asf_pkg::TX_DATA: begin
                     d.tx_sh = q.tx_sh >> 1;
                     if (q.tx_bits != last_bit) begin
                        d.tx_bits = q.tx_bits + 1'b1;
                        d.tx_low  = ~q.tx_sh[1];
                     end else if (par_en) begin
                        d.tx_st  = asf_pkg::TX_PARITY;
                        d.tx_low = ~q.tx_par;
                     end else begin
                        d.tx_st    = asf_pkg::TX_STOP;
                        d.tx_low   = 1'b0;
                        d.tx_stops = q.cfg[asf_pkg::CFG_TWO_STOP];
                     end
                  end
                  asf_pkg::TX_PARITY: begin
                     d.tx_st    = asf_pkg::TX_STOP;
                     d.tx_low   = 1'b0;
                     d.tx_stops = q.cfg[asf_pkg::CFG_TWO_STOP];
                  end
                  asf_pkg::TX_STOP: begin
                     if (q.tx_stops) begin
                        d.tx_stops = 1'b0;
                     end else begin
                        d.tx_st   = asf_pkg::TX_IDLE;
                        d.tx_done = 1'b1;
                     end
                  end
                  default: d.tx_st = asf_pkg::TX_IDLE;
               endcase
            end
         end
      end
      if (!q.cfg[asf_pkg::CFG_TX_EN]) begin
         d.tx_st  = asf_pkg::TX_IDLE;
         d.tx_low = 1'b0;
         d.tx_cnt = '0;
      end

      // ****************************************************************
      // Receiver, own shift register for full duplex
      // ****************************************************************
      sin = q.ctrl[asf_pkg::CTRL_PIN_SEL] ? PIN_I[asf_pkg::PIN_SIN]
                                          : 1'b1;
      if (tick && async_mode) begin
         case (q.rx_st)
            asf_pkg::RX_IDLE: begin
               if (!sin) begin
                  d.rx_st  = asf_pkg::RX_START;
                  d.rx_cnt = '0;
               end
            end
            asf_pkg::RX_START: begin
               // Mid-bit recheck rejects short glitches
               if (q.rx_cnt != HALF_TICK) begin
                  d.rx_cnt = q.rx_cnt + 1'b1;
               end else if (sin) begin
                  d.rx_st = asf_pkg::RX_IDLE;
               end else begin
                  d.rx_st   = asf_pkg::RX_DATA;
                  d.rx_cnt  = '0;
                  d.rx_bits = 4'h0;
                  d.rx_par  = 1'b0;
                  d.rx_sh   = 8'h00;
               end
            end
            default: begin
               if (q.rx_cnt != LAST_TICK) begin
                  d.rx_cnt = q.rx_cnt + 1'b1;
               end else begin
                  d.rx_cnt = '0;
                  if (q.rx_st == asf_pkg::RX_DATA) begin
                     d.rx_par = q.rx_par ^ sin;
                     d.rx_sh  = msb_first ? {q.rx_sh[6:0], sin}
                                          : {sin, q.rx_sh[7:1]};
                     if (q.rx_bits != last_bit) begin
                        d.rx_bits = q.rx_bits + 1'b1;
                     end else begin
                        d.rx_st = par_en ? asf_pkg::RX_PARITY
                                         : asf_pkg::RX_STOP;
                     end
                  end else if (q.rx_st == asf_pkg::RX_PARITY) begin
                     d.rx_par = q.rx_par ^ sin;
                     d.rx_st  = asf_pkg::RX_STOP;
                  end else begin
                     d.rx_st   = asf_pkg::RX_IDLE;
                     d.rx_data = (!msb_first && !eight) ? q.rx_sh >> 1
                                                        : q.rx_sh;
                     if (!sin) d.ferr = 1'b1;
                     if (par_en && (q.rx_par ^ par_odd)) begin
                        d.perr = 1'b1;
                     end
                     // A same-cycle acknowledge still counts as overrun
                     if (q.rx_full) d.oerr = 1'b1;
                     d.rx_full = 1'b1;
                  end
               end
            end
         endcase
      end
      if (!q.cfg[asf_pkg::CFG_RX_EN] || !async_mode) begin
         d.rx_st = asf_pkg::RX_IDLE;
         d.rx_cnt = '0;
      end
      if (!q.cfg[asf_pkg::CFG_RX_EN]) begin
         d.perr    = 1'b0;
         d.ferr    = 1'b0;
         d.oerr    = 1'b0;
         d.rx_full = 1'b0;
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // ****************************************************************
   // Pins
   // ****************************************************************
   always_comb begin
      PIN_PAD = PORT_PAD;
      if (q.ctrl[asf_pkg::CTRL_PIN_SEL]) begin
         PIN_PAD.o[asf_pkg::PIN_SIN]   = 1'b0;
         PIN_PAD.oe[asf_pkg::PIN_SIN]  = 1'b0;
         PIN_PAD.o[asf_pkg::PIN_SOUT]  = ~q.tx_low;
         PIN_PAD.oe[asf_pkg::PIN_SOUT] = 1'b1;
      end
   end

endmodule : asf_serial

`default_nettype wire

// ==== testbench/asf_serial_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none

module asf_serial_chk #(
   parameter int OVERSAMPLE = asf_pkg::OVERSAMPLE
) (
   input wire logic              CLOCK,
   input wire logic              RST_N,
   input wire logic              S_AXI_AWVALID,
   input wire logic              S_AXI_AWREADY,
   input wire logic              S_AXI_WVALID,
   input wire logic              S_AXI_WREADY,
   input wire logic              S_AXI_BVALID,
   input wire logic              S_AXI_BREADY,
   input wire logic [1:0]        S_AXI_BRESP,
   input wire logic              S_AXI_ARVALID,
   input wire logic              S_AXI_RVALID,
   input wire logic              S_AXI_RREADY,
   input wire logic              TIMER_TICK,
   input wire asf_pkg::asf_pad_t PORT_PAD,
   input wire asf_pkg::asf_pad_t PIN_PAD,
   input wire logic              TX_DONE
);
   // ****************************************************************
   // Bit length tracking
   // ****************************************************************
   // Counts timer ticks per line level; needs ticks two cycles apart
   logic        line;
   logic        line_q;
   logic        oe_q;
   logic [15:0] cnt_q;
   assign line = PIN_PAD.o[asf_pkg::PIN_SOUT];
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         line_q <= 1'b1;
         oe_q   <= 1'b0;
         cnt_q  <= 16'h0000;
      end else begin
         line_q <= line;
         oe_q   <= PIN_PAD.oe[asf_pkg::PIN_SOUT];
         cnt_q  <= (line != line_q) ? 16'(TIMER_TICK)
                                    : cnt_q + 16'(TIMER_TICK);
      end
   end
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RST_N);
   wr_take_a: assert property (S_AXI_AWVALID && S_AXI_WVALID &&
      !S_AXI_BVALID |=> S_AXI_BVALID) else $error("write not answered");
   rd_take_a: assert property (S_AXI_ARVALID && !S_AXI_RVALID
      |=> S_AXI_RVALID) else $error("read not answered");
   ready_pair_a: assert property (S_AXI_WREADY == S_AXI_AWREADY &&
      S_AXI_AWREADY == (S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID))
      else $error("write ready wrong");
   b_done_a: assert property (S_AXI_BVALID && S_AXI_BREADY
      |=> !S_AXI_BVALID) else $error("response not released");
   r_done_a: assert property (S_AXI_RVALID && S_AXI_RREADY
      |=> !S_AXI_RVALID) else $error("read data not released");
   port_pass_a: assert property (PIN_PAD.o[3:2] == PORT_PAD.o[3:2] &&
      PIN_PAD.oe[3:2] == PORT_PAD.oe[3:2]) else $error("port pins taken");
   port_mode_a: assert property (!PIN_PAD.oe[1] |->
      PIN_PAD == PORT_PAD) else $error("pins used while off");
   sin_free_a: assert property (PIN_PAD.oe[1] && !PORT_PAD.oe[1]
      |-> !PIN_PAD.oe[0]) else $error("serial input driven");
   bit_len_a: assert property (line && !line_q && oe_q &&
      PIN_PAD.oe[1] |-> cnt_q != 0 && cnt_q % OVERSAMPLE == 0)
      else $error("low run not whole bits");
   done_high_a: assert property ($rose(TX_DONE) && PIN_PAD.oe[1]
      |-> line [*2]) else $error("line low at frame end");
   cover property (S_AXI_BVALID && S_AXI_BRESP == asf_pkg::RESP_SLVERR);
   cover property ($rose(TX_DONE));
   cover property ($fell(line) && PIN_PAD.oe[1]);
endmodule : asf_serial_chk

bind asf_serial asf_serial_chk #(.OVERSAMPLE(OVERSAMPLE)) chk (
   .CLOCK, .RST_N, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID,
   .S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_BRESP,
   .S_AXI_ARVALID, .S_AXI_RVALID, .S_AXI_RREADY, .TIMER_TICK,
   .PORT_PAD, .PIN_PAD, .TX_DONE);

`default_nettype wire

// ==== testbench/asf_far_rx.sv ====
`timescale 1ns/1ps
`default_nettype none

module asf_far_rx (
   input wire logic        clk,
   input wire logic        line,
   input wire logic [31:0] cpb,
   input wire logic [31:0] nb,
   output logic [11:0]     frame,
   output int              fcount
);
   // ****************************************************************
   // Far receiver, samples mid bit
   // ****************************************************************
   int i;
   initial begin
      frame = 12'h000;
      fcount = 0;
      forever begin
         @(negedge line);
         repeat (cpb / 2) @(posedge clk);
         for (i = 0; i < nb; i++) begin
            frame[i] = line;
            // No wait after last stop; next start caught
            if (i < nb - 1) repeat (cpb) @(posedge clk);
         end
         fcount++;
      end
   end
endmodule : asf_far_rx

`default_nettype wire

// ==== testbench/test_async_serial_frame_transmitter.sv ====
`timescale 1ns/1ps
`default_nettype none

module test_async_serial_frame_transmitter;
   // ****************************************************************
   // Stimulus and checks
   // ****************************************************************
   logic              CLOCK = 1'b0;
   logic              RST_N = 1'b0;
   logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic              arvalid = 1'b0, rready = 1'b0;
   logic [7:0]        awaddr = 8'h00, araddr = 8'h00, tcnt = 8'h00;
   logic [31:0]       wdata = 32'h0000_0000;
   logic              timer_tick = 1'b0, osc_tick = 1'b0;
   asf_pkg::asf_pad_t port_pad = '0;
   asf_pkg::asf_pad_t pin_pad;
   logic [3:0]        pin_i;
   logic              awready, wready, bvalid, arready, rvalid;
   logic              tx_done, rx_full;
   logic [1:0]        bresp, rresp;
   logic [31:0]       rdata;
   logic [11:0]       frame;
   int                err_count = 0, checked = 0, cpb = 8, nb = 10, fcount;
   localparam logic [14:0] CASES [6] = '{15'h01a5, 15'h02d3, 15'h1f3c,
                                         15'h36eb, 15'h4bf0, 15'h7181};
   initial forever #50 CLOCK = ~CLOCK;
   always @(posedge CLOCK) begin
      tcnt <= tcnt + 8'h01;
      timer_tick <= tcnt[0];
      osc_tick <= tcnt[1:0] == 2'h3;
      port_pad <= asf_pkg::asf_pad_t'({tcnt[7:4], 4'hc});
   end
   // Undriven pins rest high through pull-ups
   assign pin_i = (pin_pad.o & pin_pad.oe) | ~pin_pad.oe;
   asf_serial #(.OVERSAMPLE(4)) uut (.CLOCK(CLOCK), .RST_N(RST_N),
      .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_AWADDR(awaddr), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_BVALID(bvalid),
      .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready), .S_AXI_ARADDR(araddr),
      .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata),
      .S_AXI_RRESP(rresp), .TIMER_TICK(timer_tick), .OSC_TICK(osc_tick),
      .PORT_PAD(port_pad), .PIN_I(pin_i), .PIN_PAD(pin_pad),
      .TX_DONE(tx_done), .RX_FULL(rx_full));
   asf_far_rx far (.clk(CLOCK), .line(pin_i[asf_pkg::PIN_SOUT]), .cpb(cpb),
      .nb(nb), .frame(frame), .fcount(fcount));

   task automatic close_out;
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : close_out

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         $display("wrong value at %0t: %h vs %h", $time, got, exp);
         err_count++;
      end
   endtask : chk

   task automatic hang(input int n);
      if (n >= 2000) err_count++;
      if (n >= 2000) close_out();
   endtask : hang

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      int n;
      @(posedge CLOCK);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; awready !== 1'b1 && n < 2000; n++) @(posedge CLOCK);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      for (; bvalid !== 1'b1 && n < 2000; n++) @(posedge CLOCK);
      bready <= 1'b0;
      hang(n);
      chk({30'h0, bresp}, {30'h0, er});
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
      int n;
      @(posedge CLOCK);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; arready !== 1'b1 && n < 2000; n++) @(posedge CLOCK);
      arvalid <= 1'b0;
      for (; rvalid !== 1'b1 && n < 2000; n++) @(posedge CLOCK);
      rready <= 1'b0;
      hang(n);
      chk(rdata, ed);
      chk({30'h0, rresp}, {30'h0, er});
   endtask : rd

   task automatic reset_case;
      chk(32'(pin_pad), 32'(port_pad));
      rd(asf_pkg::ADDR_CTRL, 32'h0000_0000, asf_pkg::RESP_OKAY);
      rd(asf_pkg::ADDR_CFG, 32'h0000_0000, asf_pkg::RESP_OKAY);
      rd(asf_pkg::ADDR_CMD, 32'h0000_0000, asf_pkg::RESP_OKAY);
      rd(8'h20, 32'h0000_0000, asf_pkg::RESP_SLVERR);
      wr(8'h20, 32'h0000_00ff, asf_pkg::RESP_SLVERR);
   endtask : reset_case

   task automatic refuse_case;
      int f0;
      f0 = fcount;
      wr(asf_pkg::ADDR_CFG, 32'h0000_0000, asf_pkg::RESP_OKAY);
      wr(asf_pkg::ADDR_CTRL, 32'h0000_0005, asf_pkg::RESP_OKAY);
      wr(asf_pkg::ADDR_CMD, 32'h0000_0001, asf_pkg::RESP_OKAY);
      // Room for a whole frame that must not appear
      repeat (300) @(posedge CLOCK);
      chk({30'h0, rx_full, tx_done}, 32'h0000_0000);
      chk(32'(fcount - f0), 32'h0000_0000);
   endtask : refuse_case

   task automatic frame_case(input logic [14:0] c);
      logic [7:0]  d;
      logic [11:0] ef;
      int          nd, n, f0, i;
      d = c[7:0];
      nd = c[8] ? 8 : 7;
      if (!c[8]) d[7] = 1'b0;
      ef = 12'h000;
      for (i = 0; i < nd; i++) ef[1 + i] = c[11] ? d[nd - 1 - i] : d[i];
      ef[1 + nd] = c[9] ? (^d) ^ c[10] : 1'b1;
      nb = 2 + nd + int'(c[9]) + int'(c[12]);
      for (i = 2 + nd; i < nb; i++) ef[i] = 1'b1;
      cpb = 8 << c[14:13];
      wr(asf_pkg::ADDR_CFG, 32'h0000_0000, asf_pkg::RESP_OKAY);
      wr(asf_pkg::ADDR_CTRL, {25'h0, c[14:13], c[10], c[9], 1'b1, c[8],
         1'b1}, asf_pkg::RESP_OKAY);
      wr(asf_pkg::ADDR_CFG, {28'h0, c[11], c[12], 2'h1},
         asf_pkg::RESP_OKAY);
      wr(asf_pkg::ADDR_TXDATA, {24'h0, c[7:0]}, asf_pkg::RESP_OKAY);
      f0 = fcount;
      wr(asf_pkg::ADDR_CMD, 32'h0000_0001, asf_pkg::RESP_OKAY);
      for (n = 0; tx_done !== 1'b1 && n < 2000; n++) @(posedge CLOCK);
      hang(n);
      chk({31'h0, n >= nb * cpb - cpb / 2 && n <= nb * cpb + cpb / 2},
          32'h0000_0001);
      chk(32'(fcount - f0), 32'h0000_0001);
      chk({20'h0, frame & ~(12'hfff << nb)}, {20'h0, ef});
      wr(asf_pkg::ADDR_STATUS, 32'h0000_0001, asf_pkg::RESP_OKAY);
      chk({31'h0, tx_done}, 32'h0000_0000);
   endtask : frame_case

   initial begin
      repeat (10) @(posedge CLOCK);
      RST_N <= 1'b1;
      reset_case();
      refuse_case();
      for (int k = 0; k < 6; k++) frame_case(CASES[k]);
      close_out();
   end
endmodule : test_async_serial_frame_transmitter

`default_nettype wire
